// ===== src/ppc_pin_ctrl.sv
// Contract
// - Error alert pulled low on error event
// - Attach flag pulled low while attach flagged
// - Charging flag pulled low while charging active and the port is active
// - Bus variant sleeps until controls or bits activate
// - Busless variant sleeps while controls and CTRL_DET_EN inactive
// - Effective control is pin OR register bit
// - Enable and mode select pins filtered against short glitches
// - Status outputs only low or released
// - Bus data pin open-drain, also sampled
// - Enable polarity latched from select at power-up
// - Attach only after current qualified long enough
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps

module ppc_pin_ctrl #(
    parameter bit HAS_BUS = 1'b1,
    parameter bit HAS_ATTACH = 1'b1,
    parameter bit HAS_CHARGE = 1'b0,
    parameter int FILT_CYCLES = ppc_pkg::GLITCH_CYC,
    parameter int QUAL_CYCLES = ppc_pkg::DET_QUAL_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Control pins
    input wire logic port_switch_enable,
    input wire logic polarity_select,
    input wire logic mode_select_1,
    input wire logic mode_select_2,
    input wire logic emulation_mode_select,
    // Analog side events
    input wire logic error_event,
    input wire logic port_current_high,
    input wire logic charging_active,
    // Error alert open-drain pin
    input wire logic error_flag_n_in,
    output logic error_flag_n_out,
    output logic error_flag_n_oe,
    // Attach open-drain pin
    input wire logic attach_flag_n_in,
    output logic attach_flag_n_out,
    output logic attach_flag_n_oe,
    // Charging open-drain pin
    input wire logic charging_flag_n_in,
    output logic charging_flag_n_out,
    output logic charging_flag_n_oe,
    // Management bus data pin
    input wire logic bus_data_in,
    output logic bus_data_out,
    output logic bus_data_oe,
    input wire logic bus_data_pull_low,
    output logic bus_data_rx,
    // Power state and interrupt
    output logic port_active,
    output logic irq
);

    localparam int NIN = 4;

    // Refuse settings the counters cannot serve
    if (FILT_CYCLES < 1 || FILT_CYCLES > 255) begin : g_bad_filt
        $error("FILT_CYCLES out of range");
    end
    if (QUAL_CYCLES < 1 || QUAL_CYCLES > 65535) begin : g_bad_qual
        $error("QUAL_CYCLES out of range");
    end

    // Byte offset match on an aligned word
    function automatic logic ofs_hit(input logic [7:0] addr, input logic [7:0] ofs);
        ofs_hit = (addr[7:2] == ofs[7:2]);
    endfunction

    // Offset belongs to the map
    function automatic logic ofs_mapped(input logic [7:0] addr);
        ofs_mapped = ofs_hit(addr, ppc_pkg::OFS_CTRL) || ofs_hit(addr, ppc_pkg::OFS_STATUS)
            || ofs_hit(addr, ppc_pkg::OFS_IRQ_STAT) || ofs_hit(addr, ppc_pkg::OFS_IRQ_MASK);
    endfunction

    logic [NIN-1:0] raw_pins;
    logic [NIN-1:0] filt_ff;
    logic [7:0] filt_cnt_ff [NIN];
    logic pol_ff;
    logic pol_done_ff;
    logic [ppc_pkg::CTRL_W-1:0] ctrl_ff;
    logic [ppc_pkg::IRQ_W-1:0] irq_stat_ff;
    logic [ppc_pkg::IRQ_W-1:0] irq_mask_ff;
    ppc_pkg::ppc_state_t state_ff;
    ppc_pkg::ppc_state_t nxt_state;
    logic [15:0] qual_cnt_ff;
    logic attach_ff;
    logic charging_ff;
    logic en_pin_dec;
    logic eff_en;
    logic eff_m1;
    logic eff_m2;
    logic eff_emu;
    logic run_ok;
    logic chg_now;
    logic [ppc_pkg::IRQ_W-1:0] irq_set;
    logic [ppc_pkg::IRQ_W-1:0] irq_clr;
    logic aw_got_ff;
    logic w_got_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic wr_fire;
    logic [31:0] status_word;

    assign raw_pins = {emulation_mode_select, mode_select_2, mode_select_1, port_switch_enable};

    // Accept a new pin level only after it held steady for the window
    always_ff @(posedge aclk) begin
        for (int i = 0; i < NIN; i++) begin
            if (!aresetn) begin
                filt_ff[i] <= 1'b0;
                filt_cnt_ff[i] <= 8'h00;
            end else if (raw_pins[i] == filt_ff[i]) begin
                filt_cnt_ff[i] <= 8'h00;
            end else if (filt_cnt_ff[i] >= 8'(FILT_CYCLES - 1)) begin
                filt_ff[i] <= raw_pins[i];
                filt_cnt_ff[i] <= 8'h00;
            end else begin
                filt_cnt_ff[i] <= filt_cnt_ff[i] + 8'h01;
            end
        end
    end

    // Polarity caught once at the first edge after release; later changes ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pol_done_ff <= 1'b0;
            pol_ff <= 1'b0;
        end else if (!pol_done_ff) begin
            pol_done_ff <= 1'b1;
            pol_ff <= polarity_select;
        end
    end

    // Decode pin polarity first so a set register bit always enables
    assign en_pin_dec = pol_done_ff && (filt_ff[0] == pol_ff);
    assign eff_en = en_pin_dec || (HAS_BUS && ctrl_ff[ppc_pkg::CTRL_EN_SET]);
    assign eff_m1 = filt_ff[1] || (HAS_BUS && ctrl_ff[ppc_pkg::CTRL_M1_SET]);
    assign eff_m2 = filt_ff[2] || (HAS_BUS && ctrl_ff[ppc_pkg::CTRL_M2_SET]);
    assign eff_emu = filt_ff[3] || (HAS_BUS && ctrl_ff[ppc_pkg::CTRL_EMU_SET]);
    // Busless parts see only pins, so nothing else can make them active
    assign run_ok = eff_en && (eff_m1 || eff_m2 || eff_emu);

    // Power state selection
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ppc_pkg::PPC_SLEEP, ppc_pkg::PPC_DETECT: begin
                if (run_ok) begin
                    nxt_state = ppc_pkg::PPC_ACTIVE;
                end else if (ctrl_ff[ppc_pkg::CTRL_DET_EN] && HAS_ATTACH) begin
                    nxt_state = ppc_pkg::PPC_DETECT;
                end else begin
                    nxt_state = ppc_pkg::PPC_SLEEP;
                end
            end
            ppc_pkg::PPC_ACTIVE: begin
                if (!run_ok) begin
                    nxt_state = ppc_pkg::PPC_SLEEP;
                end
            end
            default: nxt_state = ppc_pkg::PPC_SLEEP;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ppc_pkg::PPC_SLEEP;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Attach qualification; no sensing while asleep
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            qual_cnt_ff <= 16'h0000;
            attach_ff <= 1'b0;
        end else if (!HAS_ATTACH || state_ff == ppc_pkg::PPC_SLEEP || !port_current_high) begin
            qual_cnt_ff <= 16'h0000;
            attach_ff <= 1'b0;
        end else if (qual_cnt_ff >= 16'(QUAL_CYCLES)) begin
            attach_ff <= 1'b1;
        end else begin
            qual_cnt_ff <= qual_cnt_ff + 16'h0001;
        end
    end

    // Charging counts only while the port is powered
    assign chg_now = HAS_CHARGE && charging_active && (state_ff == ppc_pkg::PPC_ACTIVE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            charging_ff <= 1'b0;
        end else begin
            charging_ff <= chg_now;
        end
    end

    // Error event level and the rising edges of the other events feed the sticky bits
    always_comb begin
        irq_set = '0;
        irq_set[ppc_pkg::IRQ_ERR] = error_event;
        irq_set[ppc_pkg::IRQ_ATTACH] = (qual_cnt_ff >= 16'(QUAL_CYCLES)) && !attach_ff
            && port_current_high && HAS_ATTACH && (state_ff != ppc_pkg::PPC_SLEEP);
        irq_set[ppc_pkg::IRQ_CHARGE] = chg_now && !charging_ff;
        irq_set[ppc_pkg::IRQ_ACTIVE] = (nxt_state == ppc_pkg::PPC_ACTIVE)
            && (state_ff != ppc_pkg::PPC_ACTIVE);
    end

    // AXI write channels taken independently, response after both
    assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_got_ff && !s_axi_bvalid;
    assign wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            awaddr_ff <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_got_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_ff <= 1'b0;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_got_ff <= 1'b0;
        end
    end

    // Write response; unmapped offsets answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ppc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= ofs_mapped(awaddr_ff) ? ppc_pkg::RESP_OKAY : ppc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control and mask writes; all fields sit in byte lane 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= ppc_pkg::CTRL_RST;
            irq_mask_ff <= ppc_pkg::IRQ_MASK_RST;
        end else if (wr_fire && wstrb_ff[0]) begin
            if (ofs_hit(awaddr_ff, ppc_pkg::OFS_CTRL)) begin
                ctrl_ff <= wdata_ff[ppc_pkg::CTRL_W-1:0];
            end
            if (ofs_hit(awaddr_ff, ppc_pkg::OFS_IRQ_MASK)) begin
                irq_mask_ff <= wdata_ff[ppc_pkg::IRQ_W-1:0];
            end
        end
    end

    // Write one to clear; a new event in the same cycle wins
    assign irq_clr = (wr_fire && wstrb_ff[0] && ofs_hit(awaddr_ff, ppc_pkg::OFS_IRQ_STAT))
        ? wdata_ff[ppc_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_ff <= '0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);

    // Status readback
    always_comb begin
        status_word = 32'h00000000;
        status_word[ppc_pkg::ST_EFF_EN] = eff_en;
        status_word[ppc_pkg::ST_EFF_M1] = eff_m1;
        status_word[ppc_pkg::ST_EFF_M2] = eff_m2;
        status_word[ppc_pkg::ST_EFF_EMU] = eff_emu;
        status_word[ppc_pkg::ST_POL] = pol_ff;
        status_word[ppc_pkg::ST_STATE_LO +: 2] = state_ff;
        status_word[ppc_pkg::ST_ATTACH] = attach_ff;
        status_word[ppc_pkg::ST_ERR_PIN] = error_flag_n_in;
        status_word[ppc_pkg::ST_ATT_PIN] = attach_flag_n_in;
        status_word[ppc_pkg::ST_CHG_PIN] = charging_flag_n_in;
        status_word[ppc_pkg::ST_BUSDATA] = bus_data_rx;
    end

    // One read at a time; data one cycle after the address
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= ppc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= ppc_pkg::RESP_OKAY;
            if (ofs_hit(s_axi_araddr, ppc_pkg::OFS_CTRL)) begin
                s_axi_rdata <= {{(32 - ppc_pkg::CTRL_W){1'b0}}, ctrl_ff};
            end else if (ofs_hit(s_axi_araddr, ppc_pkg::OFS_STATUS)) begin
                s_axi_rdata <= status_word;
            end else if (ofs_hit(s_axi_araddr, ppc_pkg::OFS_IRQ_STAT)) begin
                s_axi_rdata <= {{(32 - ppc_pkg::IRQ_W){1'b0}}, irq_stat_ff};
            end else if (ofs_hit(s_axi_araddr, ppc_pkg::OFS_IRQ_MASK)) begin
                s_axi_rdata <= {{(32 - ppc_pkg::IRQ_W){1'b0}}, irq_mask_ff};
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= ppc_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Open-drain drivers: data always low, only the enable moves
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            error_flag_n_oe <= 1'b0;
            attach_flag_n_oe <= 1'b0;
            charging_flag_n_oe <= 1'b0;
            bus_data_oe <= 1'b0;
            bus_data_rx <= 1'b1;
            port_active <= 1'b0;
        end else begin
            error_flag_n_oe <= irq_stat_ff[ppc_pkg::IRQ_ERR];
            attach_flag_n_oe <= HAS_ATTACH && attach_ff;
            charging_flag_n_oe <= charging_ff;
            bus_data_oe <= HAS_BUS && bus_data_pull_low;
            bus_data_rx <= bus_data_in;
            port_active <= (state_ff == ppc_pkg::PPC_ACTIVE);
        end
    end

    // Never drive high; pull-ups give the idle level
    assign error_flag_n_out = 1'b0;
    assign attach_flag_n_out = 1'b0;
    assign charging_flag_n_out = 1'b0;
    assign bus_data_out = 1'b0;

endmodule

// ===== include/ppc_pkg.sv
// Shared constants for the port power controller pin logic
package ppc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;

    // Control register fields: set bits OR'd with the matching pins; CTRL_DET_EN has no pin
    localparam int CTRL_EN_SET = 0;
    localparam int CTRL_M1_SET = 1;
    localparam int CTRL_M2_SET = 2;
    localparam int CTRL_EMU_SET = 3;
    localparam int CTRL_DET_EN = 4;
    localparam int CTRL_W = 5;
    localparam logic [4:0] CTRL_RST = 5'h00;

    // Status register fields
    localparam int ST_EFF_EN = 0;
    localparam int ST_EFF_M1 = 1;
    localparam int ST_EFF_M2 = 2;
    localparam int ST_EFF_EMU = 3;
    localparam int ST_POL = 4;
    localparam int ST_STATE_LO = 5;
    localparam int ST_ATTACH = 7;
    localparam int ST_ERR_PIN = 8;
    localparam int ST_ATT_PIN = 9;
    localparam int ST_CHG_PIN = 10;
    localparam int ST_BUSDATA = 11;

    // Interrupt bits, same layout in status and mask
    localparam int IRQ_ERR = 0;
    localparam int IRQ_ATTACH = 1;
    localparam int IRQ_CHARGE = 2;
    localparam int IRQ_ACTIVE = 3;
    localparam int IRQ_W = 4;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int T_DET_QUAL_US = 200;
    localparam int DET_QUAL_CYC = (T_DET_QUAL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_GLITCH_NS = 120;
    localparam int GLITCH_CYC = (T_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Power states
    typedef enum logic [1:0] {
        PPC_SLEEP,
        PPC_DETECT,
        PPC_ACTIVE
    } ppc_state_t;
endpackage

// ===== tb/ppc_pin_ctrl_chk.sv
`timescale 1ns/1ps
// Watches pin and bus behaviour from the top ports only
module ppc_pin_ctrl_chk #(
    parameter int QUAL_CYCLES = 20
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Events and pins
    input wire logic error_event,
    input wire logic port_current_high,
    input wire logic bus_data_pull_low,
    input wire logic error_flag_n_out,
    input wire logic error_flag_n_oe,
    input wire logic attach_flag_n_out,
    input wire logic attach_flag_n_oe,
    input wire logic charging_flag_n_out,
    input wire logic bus_data_out,
    input wire logic bus_data_oe,
    input wire logic port_active
);
    int cur_cnt_ff;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Run length of the current comparator, saturating so it never wraps
    always_ff @(posedge aclk) begin
        if (!aresetn || !port_current_high) cur_cnt_ff <= 0;
        else if (cur_cnt_ff < 100000) cur_cnt_ff <= cur_cnt_ff + 1;
    end

    err_alert_a: assert property (error_event |-> ##2 error_flag_n_oe)
        else $error("error alert not pulled low");
    od_low_a: assert property (!error_flag_n_out && !attach_flag_n_out && !charging_flag_n_out)
        else $error("status output driven high");
    bus_pull_a: assert property (bus_data_pull_low |=> bus_data_oe && !bus_data_out)
        else $error("bus data not pulled low");
    bus_release_a: assert property (!bus_data_pull_low |=> !bus_data_oe)
        else $error("bus data not released");
    attach_qual_a: assert property ($rose(attach_flag_n_oe) |-> $past(cur_cnt_ff, 2) >= QUAL_CYCLES)
        else $error("attach flagged before qualification");
    attach_drop_a: assert property (!port_current_high |-> ##2 !attach_flag_n_oe)
        else $error("attach flag held without current");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not withdrawn");
    write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer not withdrawn");

    // Main scenarios reached
    cover property ($rose(error_flag_n_oe));
    cover property ($rose(attach_flag_n_oe));
    cover property ($rose(port_active));
endmodule

bind ppc_pin_ctrl ppc_pin_ctrl_chk #(.QUAL_CYCLES(QUAL_CYCLES)) chk_i (
    .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_bvalid, .s_axi_bready, .error_event, .port_current_high, .bus_data_pull_low,
    .error_flag_n_out, .error_flag_n_oe, .attach_flag_n_out, .attach_flag_n_oe,
    .charging_flag_n_out, .bus_data_out, .bus_data_oe, .port_active
);

// ===== tb/ppc_host_model.sv
`timescale 1ns/1ps
// Host board: straps on the control pins, pull-ups on the open-drain lines
module ppc_host_model (
    // Commands from the bench
    input wire logic en_cmd,
    input wire logic [2:0] mode_cmd,
    input wire logic polarity_select,
    // Control pins
    output logic port_switch_enable,
    output logic mode_select_1,
    output logic mode_select_2,
    output logic emulation_mode_select,
    // Open-drain lines
    input wire logic error_flag_n_oe,
    input wire logic attach_flag_n_oe,
    input wire logic charging_flag_n_oe,
    input wire logic bus_data_oe,
    output logic error_flag_n_in,
    output logic attach_flag_n_in,
    output logic charging_flag_n_in,
    output logic bus_data_in
);
    // Enable driven at the level the polarity select decodes to
    assign port_switch_enable = en_cmd ? polarity_select : !polarity_select;
    // Selectors driven as commanded; all low only when a test asks
    assign {emulation_mode_select, mode_select_2, mode_select_1} = mode_cmd;
    // Released lines float up to the pull-up level
    assign error_flag_n_in = !error_flag_n_oe;
    assign attach_flag_n_in = !attach_flag_n_oe;
    assign charging_flag_n_in = !charging_flag_n_oe;
    assign bus_data_in = !bus_data_oe;
endmodule

// ===== tb/ppc_pin_ctrl_tb.sv
`timescale 1ns/1ps
module ppc_pin_ctrl_tb;
    logic aclk, aresetn, en_cmd;
    logic [2:0] mode_cmd;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic port_switch_enable, polarity_select, mode_select_1, mode_select_2, emulation_mode_select;
    logic error_event, port_current_high, charging_active, bus_data_pull_low, bus_data_rx;
    logic error_flag_n_in, error_flag_n_out, error_flag_n_oe, attach_flag_n_in, attach_flag_n_out;
    logic attach_flag_n_oe, charging_flag_n_in, charging_flag_n_out, charging_flag_n_oe;
    logic bus_data_in, bus_data_out, bus_data_oe, port_active, irq;
    int miscompares, comparisons;

    ppc_pin_ctrl #(.HAS_CHARGE(1'b1), .QUAL_CYCLES(20)) dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .port_switch_enable, .polarity_select, .mode_select_1,
        .mode_select_2, .emulation_mode_select, .error_event, .port_current_high,
        .charging_active, .error_flag_n_in, .error_flag_n_out, .error_flag_n_oe,
        .attach_flag_n_in, .attach_flag_n_out, .attach_flag_n_oe, .charging_flag_n_in,
        .charging_flag_n_out, .charging_flag_n_oe, .bus_data_in, .bus_data_out, .bus_data_oe,
        .bus_data_pull_low, .bus_data_rx, .port_active, .irq
    );
    ppc_host_model host (
        .en_cmd, .mode_cmd, .polarity_select, .port_switch_enable, .mode_select_1,
        .mode_select_2, .emulation_mode_select, .error_flag_n_oe, .attach_flag_n_oe,
        .charging_flag_n_oe, .bus_data_oe, .error_flag_n_in, .attach_flag_n_in,
        .charging_flag_n_in, .bus_data_in
    );

    // Free-running 25 MHz clock
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic summarize();
        if (miscompares == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chk1(input logic seen, input logic exp);
        chk({31'h0, seen}, {31'h0, exp});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Handshakes are sampled mid-cycle so the decision never races the edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_t, w_t, b_t;
        int n;
        b_t = 1'b0;
        n = 0;
        // Let an edge pass so ready is never lowered and raised in one step
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_t && n < 50) begin
            @(negedge aclk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            b_t = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
            n++;
        end
        s_axi_bready <= 1'b0;
        chk({30'h0, rsp}, {30'h0, a > 8'h0F ? ppc_pkg::RESP_SLVERR : ppc_pkg::RESP_OKAY});
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic ar_t, r_t;
        int n;
        r_t = 1'b0;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_t && n < 50) begin
            @(negedge aclk);
            ar_t = s_axi_arvalid && s_axi_arready;
            r_t = s_axi_rvalid;
            rd_data = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (ar_t) s_axi_arvalid <= 1'b0;
            n++;
        end
        s_axi_rready <= 1'b0;
        chk({30'h0, rsp}, {30'h0, a > 8'h0F ? ppc_pkg::RESP_SLVERR : ppc_pkg::RESP_OKAY});
        chk(rd_data & m, e);
    endtask

    // Cuts a hang short
    initial begin
        repeat (5000) @(posedge aclk);
        miscompares++;
        summarize();
    end

    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, en_cmd, mode_cmd} = '0;
        {error_event, port_current_high, charging_active, bus_data_pull_low} = '0;
        s_axi_wstrb = 4'hF;
        polarity_select = 1'b1;
        aresetn = 1'b0;
        cyc(10);
        aresetn <= 1'b1;
        cyc(1);
        // Reset contents and the unmapped place
        rd_chk(ppc_pkg::OFS_CTRL, 32'hFFFFFFFF, 32'h0);
        rd_chk(ppc_pkg::OFS_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
        rd_chk(ppc_pkg::OFS_STATUS, 32'hFFF, 32'hF10);
        rd_chk(8'h10, 32'hFFFFFFFF, 32'h0);
        axi_wr(8'h14, 32'h1F);
        // Enable alone, then a selector glitch, keep it asleep; the first selector wakes it and each held in turn keeps it active
        en_cmd <= 1'b1;
        cyc(8);
        chk1(port_active, 1'b0);
        mode_cmd <= 3'h1;
        cyc(2);
        mode_cmd <= 3'h0;
        cyc(8);
        chk1(port_active, 1'b0);
        for (int i = 0; i < 3; i++) begin
            mode_cmd <= 3'h1 << i;
            cyc(8);
            rd_chk(ppc_pkg::OFS_STATUS, 32'h7F, 32'h51 | (32'h2 << i));
        end
        // Entry into active raised a status bit: masked, unmasked, cleared
        chk1(irq, 1'b0);
        axi_wr(ppc_pkg::OFS_IRQ_MASK, 32'h8);
        chk1(irq, 1'b1);
        axi_wr(ppc_pkg::OFS_IRQ_STAT, 32'h8);
        chk1(irq, 1'b0);
        en_cmd <= 1'b0;
        cyc(8);
        chk1(port_active, 1'b0);
        // Register bits stand in for the pins
        mode_cmd <= 3'h0;
        for (int i = 1; i < 4; i++) begin
            axi_wr(ppc_pkg::OFS_CTRL, 32'h1 | (32'h1 << i));
            cyc(8);
            rd_chk(ppc_pkg::OFS_STATUS, 32'h7F, 32'h51 | (32'h1 << i));
        end
        axi_wr(ppc_pkg::OFS_CTRL, 32'h0E);
        cyc(8);
        chk1(port_active, 1'b0);
        axi_wr(ppc_pkg::OFS_CTRL, 32'h03);
        cyc(8);
        charging_active <= 1'b1;
        cyc(4);
        chk1(charging_flag_n_in, 1'b0);
        charging_active <= 1'b0;
        cyc(4);
        chk1(charging_flag_n_in, 1'b1);
        // Error pulse holds the alert until cleared
        error_event <= 1'b1;
        cyc(1);
        error_event <= 1'b0;
        cyc(3);
        chk1(error_flag_n_in, 1'b0);
        rd_chk(ppc_pkg::OFS_STATUS, 32'h100, 32'h0);
        axi_wr(ppc_pkg::OFS_IRQ_STAT, 32'h1);
        cyc(2);
        chk1(error_flag_n_in, 1'b1);
        // Short current burst is ignored, a long one flags attach
        axi_wr(ppc_pkg::OFS_CTRL, 32'h10);
        cyc(4);
        port_current_high <= 1'b1;
        cyc(15);
        port_current_high <= 1'b0;
        cyc(3);
        chk1(attach_flag_n_in, 1'b1);
        port_current_high <= 1'b1;
        cyc(30);
        chk1(attach_flag_n_in, 1'b0);
        rd_chk(ppc_pkg::OFS_STATUS, 32'h2E0, 32'hA0);
        rd_chk(ppc_pkg::OFS_IRQ_STAT, 32'hF, 32'hE);
        port_current_high <= 1'b0;
        cyc(3);
        chk1(attach_flag_n_in, 1'b1);
        bus_data_pull_low <= 1'b1;
        cyc(3);
        chk1(bus_data_rx, 1'b0);
        bus_data_pull_low <= 1'b0;
        cyc(3);
        chk1(bus_data_rx, 1'b1);
        // Second reset with active-low enable
        polarity_select <= 1'b0;
        aresetn <= 1'b0;
        cyc(10);
        aresetn <= 1'b1;
        en_cmd <= 1'b1;
        mode_cmd <= 3'h2;
        cyc(8);
        chk1(port_active, 1'b1);
        rd_chk(ppc_pkg::OFS_STATUS, 32'h10, 32'h0);
        en_cmd <= 1'b0;
        cyc(8);
        chk1(port_active, 1'b0);
        axi_wr(ppc_pkg::OFS_CTRL, 32'h1);
        cyc(8);
        chk1(port_active, 1'b1);
        summarize();
    end
endmodule
